// file: fswd_watchdog.sv
`timescale 1ns/1ps

// Operation
// - watchdog starts enabled and running whenever any reset ends.
// - disable instruction works only before end-of-init; ignored afterwards.
// - counter overflow requests an internal reset of the whole chip.
// - watchdog reset drives the reset-out pin low.
// - 16-bit counter ticking at clock/2 or clock/128 per select bit.
// - service loads the high byte from the reload field.
// - timeout spans 20.48us to 336ms at 25 MHz clock.
// - end-of-init releases reset-out pin high and closes disable window.
// - no watchdog reset while in bootstrap loader mode.
// - watchdog reset sequence lasts 512 clock cycles.
module fswd_watchdog import fswd_pkg::*; (
  input wire logic clk_i, // cpu clock
  input wire logic rst_i, // chip reset, sync, active high
  input wire logic service_i, // service instruction executed
  input wire logic disable_i, // disable instruction executed
  input wire logic end_init_i, // end-of-init instruction executed
  input wire logic ctrl_wr_i, // control register write strobe
  input wire fswd_ctrl_s ctrl_i, // control register write data
  input wire logic bootstrap_i, // bootstrap loader mode active
  output logic wdt_reset_o, // internal reset request, 512 cycles
  output logic reset_out_n_o, // reset-out pin, active low
  output logic running_o, // watchdog enabled
  output logic [CNT_W-1:0] count_o // current counter value
);

  // ==========================================================
  // state
  fswd_state_e state;
  fswd_ctrl_s ctrl;
  logic enabled;
  logic end_init_done;
  logic [CNT_W-1:0] count;
  logic [PRE_W-1:0] pre;
  logic [SEQ_W-1:0] seq_cnt;
  logic tick;
  logic ovf;
  logic run;
  logic seq_done;

  function automatic logic [PRE_W-1:0] pre_last(input logic sel);
    pre_last = sel ? PRE_SLOW_LAST : PRE_FAST_LAST;
  endfunction

  // tick and overflow decode; a late switch to /2 is caught by >=
  assign run = (state == ST_RUN) && enabled;
  assign tick = run && (pre >= pre_last(ctrl.prescale_select_bit));
  assign ovf = tick && (count == CNT_TOP) && !service_i;
  assign seq_done = (state == ST_RSTSEQ) && (seq_cnt == SEQ_LAST);

  // ==========================================================
  // reset sequencer state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (ovf && !bootstrap_i) begin
            state <= ST_RSTSEQ;
          end
        end
        ST_RSTSEQ: begin
          if (seq_done) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // sequence length counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state != ST_RSTSEQ) begin
      seq_cnt <= SEQ_RST;
    end else begin
      seq_cnt <= seq_cnt + SEQ_ONE;
    end
  end

  // ==========================================================
  // control register; the sequence restores defaults like a chip reset
  always_ff @(posedge clk_i) begin
    if (rst_i || seq_done) begin
      ctrl <= CTRL_RST;
    end else if (ctrl_wr_i && state == ST_RUN) begin
      ctrl <= ctrl_i;
    end
  end

  // enable: forced on at every reset exit, off only before end-of-init
  always_ff @(posedge clk_i) begin
    if (rst_i || seq_done) begin
      enabled <= 1'b1;
    end else if (state == ST_RUN && disable_i && !end_init_done) begin
      enabled <= 1'b0;
    end
  end

  // end-of-init latch; only a reset reopens the disable window
  always_ff @(posedge clk_i) begin
    if (rst_i || seq_done) begin
      end_init_done <= 1'b0;
    end else if (state == ST_RUN && end_init_i) begin
      end_init_done <= 1'b1;
    end
  end

  // ==========================================================
  // prescaler, restarted by a service so the timeout is exact
  always_ff @(posedge clk_i) begin
    if (rst_i || !run || service_i || tick) begin
      pre <= PRE_RST;
    end else begin
      pre <= pre + PRE_ONE;
    end
  end

  // counter: service beats a same-cycle overflow, so no late reset
  always_ff @(posedge clk_i) begin
    if (rst_i || state == ST_RSTSEQ) begin
      count <= CNT_RST;
    end else if (run && service_i) begin
      count <= {ctrl.reload_value_field, LOW_BYTE_CLR};
    end else if (tick) begin
      count <= count + CNT_ONE;
    end
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= (state == ST_RUN) ? (ovf && !bootstrap_i)
                                       : !seq_done;
    end
  end

  // pin stays low until end-of-init, and again during a watchdog reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_out_n_o <= 1'b0;
    end else if (state == ST_RUN && ovf && !bootstrap_i) begin
      reset_out_n_o <= 1'b0;
    end else if (state == ST_RUN && end_init_i) begin
      reset_out_n_o <= 1'b1;
    end else if (seq_done) begin
      reset_out_n_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_o <= 1'b0;
      count_o <= CNT_RST;
    end else begin
      running_o <= enabled;
      count_o <= count;
    end
  end

  // ==========================================================
  // checks
  logic rst_q;
  logic [SEQ_W:0] hi_len;
  logic [23:0] svc_age;
  logic svc_short;

  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !wdt_reset_o) begin
      hi_len <= '0;
    end else begin
      hi_len <= hi_len + 11'h001;
    end
  end

  // cycles since last service and whether it used the shortest setting
  always_ff @(posedge clk_i) begin
    if (rst_i || (run && service_i)) begin
      svc_age <= 24'h000000;
      svc_short <= !rst_i && !ctrl_wr_i
                   && ctrl.reload_value_field == RELOAD_SHORTEST
                   && !ctrl.prescale_select_bit;
    end else begin
      svc_age <= svc_age + 24'h000001;
      // a rewrite, a wrap or a reset sequence voids the timing claim
      if (ctrl_wr_i || ovf || state == ST_RSTSEQ) begin
        svc_short <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_overflow;
    ovf && !bootstrap_i;
  endsequence

  sequence s_seq_held;
    wdt_reset_o[*8];
  endsequence

  a_start_enabled: assert property (
    rst_q |-> enabled ##1 running_o)
    else $error("watchdog not enabled after reset");
  a_disable_locked: assert property (
    state == ST_RUN && end_init_done && disable_i
    |=> enabled == $past(enabled))
    else $error("disable honoured after end of init");
  a_disable_early: assert property (
    state == ST_RUN && !end_init_done && disable_i |=> !enabled)
    else $error("disable ignored before end of init");
  a_ovf_reset: assert property (s_overflow |=> s_seq_held)
    else $error("overflow did not start reset");
  a_pin_low: assert property (wdt_reset_o |-> !reset_out_n_o)
    else $error("reset-out high during watchdog reset");
  a_boot_block: assert property (
    ovf && bootstrap_i && state == ST_RUN |=> !wdt_reset_o)
    else $error("watchdog reset in bootstrap mode");
  a_seq_length: assert property (
    $fell(wdt_reset_o) |-> $past(hi_len) == 11'(SEQ_CYCLES - 1))
    else $error("reset sequence length wrong");
  a_reload_load: assert property (
    run && service_i |=> count == {$past(ctrl.reload_value_field),
                                   LOW_BYTE_CLR})
    else $error("service did not load high byte");
  a_min_timeout: assert property (
    ovf && svc_short |-> svc_age == 24'(TMO_MIN_CYC - 1))
    else $error("shortest timeout wrong");
  a_end_init_instr_pin: assert property (
    state == ST_RUN && end_init_i && !ovf |=> reset_out_n_o)
    else $error("end of init not shown on pin");

endmodule

// file: fswd_pkg.sv
package fswd_pkg;

  // ==========================================================
  // counter geometry
  localparam int CNT_W = 16;
  localparam int RELOAD_W = 8;
  localparam int PRE_W = 7;
  localparam logic [7:0] LOW_BYTE_CLR = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_TOP = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // ==========================================================
  // prescaler divide factors
  localparam int DIV_FAST = 2;
  localparam int DIV_SLOW = 128;
  localparam logic [PRE_W-1:0] PRE_FAST_LAST = PRE_W'(DIV_FAST - 1);
  localparam logic [PRE_W-1:0] PRE_SLOW_LAST = PRE_W'(DIV_SLOW - 1);
  localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;

  // ==========================================================
  // internal reset sequence length
  localparam int SEQ_HALF_UNITS = 1024;
  localparam int SEQ_CYCLES = SEQ_HALF_UNITS / 2;
  localparam int SEQ_W = 10;
  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(SEQ_CYCLES - 1);
  localparam logic [SEQ_W-1:0] SEQ_RST = 10'h000;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 10'h001;

  // ==========================================================
  // timeout figures, given at a reference cpu clock of 25 MHz
  localparam int REF_CLK_MHZ = 25;
  localparam int TMO_MIN_NS = 20480;
  localparam int TMO_MIN_CYC = (TMO_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int TMO_FAST00_US = 5240;
  localparam int TMO_FAST00_CYC = (TMO_FAST00_US * REF_CLK_MHZ) / 1;
  localparam logic [RELOAD_W-1:0] RELOAD_SHORTEST = 8'hFF;

  // ==========================================================
  // control register image
  typedef struct packed {
    logic [RELOAD_W-1:0] reload_value_field;
    logic prescale_select_bit;
  } fswd_ctrl_s;

  localparam fswd_ctrl_s CTRL_RST = '{reload_value_field: 8'h00,
                                      prescale_select_bit: 1'b0};

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RSTSEQ = 2'b10
  } fswd_state_e;

endpackage

// file: fswd_cpu_model.sv
`timescale 1ns/1ps

// ==========================================================
// cpu side: issues one-cycle instruction strobes
module fswd_cpu_model import fswd_pkg::*; (
  input wire logic clk_i, // cpu clock
  output logic srv_o, // service strobe
  output logic dis_o, // disable strobe
  output logic ein_o, // end-of-init strobe
  output logic wr_o, // control write strobe
  output fswd_ctrl_s ctrl_o // control write data
);
  // quiet bus from time zero
  initial begin
    {srv_o, dis_o, ein_o, wr_o} = 4'h0;
    ctrl_o = CTRL_RST;
  end

  // op 0 service, 1 disable, 2 end-of-init; called just after an edge
  task automatic op(input int k, input fswd_ctrl_s c);
    if (k == 0) begin
      // control is rewritten first, a stale reload is never trusted
      ctrl_o = c;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
    end
    srv_o = (k == 0);
    dis_o = (k == 1);
    ein_o = (k == 2);
    @(posedge clk_i);
    #1 {srv_o, dis_o, ein_o} = 3'h0;
  endtask
endmodule

// file: fail_safe_watchdog_timer_bench.sv
`timescale 1ns/1ps

// ==========================================================
// bench for the fail-safe watchdog
module fail_safe_watchdog_timer_bench import fswd_pkg::*;;
  logic clk_i, rst_i, boot, srv, dis, ein, wr, wrst, rout_n, run;
  fswd_ctrl_s ctrl;
  logic [CNT_W-1:0] cnt, c0;
  int err_total = 0;
  int num_checks = 0;
  int n;
  // rows: control value, count advance over 512 cycles
  fswd_ctrl_s row_in [4] = '{'{8'h00, 1'b0}, '{8'h5A, 1'b0},
                             '{8'hA5, 1'b1}, '{8'h00, 1'b1}};
  logic [CNT_W-1:0] row_d [4] = '{16'h0100, 16'h0100, 16'h0004, 16'h0004};

  fswd_cpu_model cpu (.clk_i(clk_i), .srv_o(srv), .dis_o(dis),
    .ein_o(ein), .wr_o(wr), .ctrl_o(ctrl));
  fswd_watchdog dut (.clk_i(clk_i), .rst_i(rst_i), .service_i(srv),
    .disable_i(dis), .end_init_i(ein), .ctrl_wr_i(wr), .ctrl_i(ctrl),
    .bootstrap_i(boot), .wdt_reset_o(wrst), .reset_out_n_o(rout_n),
    .running_o(run), .count_o(cnt));

  // clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [CNT_W-1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // wait k edges, then settle past the edge
  task automatic tk(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic do_rst();
    rst_i = 1'b1;
    tk(16);
    rst_i = 1'b0;
    tk(2);
  endtask

  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog on the bench itself: a hang counts as a mismatch
  initial begin
    #(25 * 20000);
    err_total++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    boot = 1'b0;
    do_rst();
    chk(run, 1'b1);
    chk(rout_n, 1'b0);
    // reload loads high byte, low byte cleared, rate per select bit
    for (int i = 0; i < 4; i++) begin
      cpu.op(0, row_in[i]);
      tk(2);
      chk(cnt, {row_in[i].reload_value_field, LOW_BYTE_CLR});
      c0 = cnt;
      tk(512);
      chk(cnt - c0, row_d[i]);
    end
    // disable honoured before end-of-init, counter then holds
    cpu.op(1, CTRL_RST);
    tk(2);
    chk(run, 1'b0);
    c0 = cnt;
    tk(20);
    chk(cnt, c0);
    // a chip reset re-enables; after end-of-init disable is ignored
    do_rst();
    chk(run, 1'b1);
    cpu.op(2, CTRL_RST);
    tk(1);
    chk(rout_n, 1'b1);
    cpu.op(1, CTRL_RST);
    tk(3);
    chk(run, 1'b1);
    // shortest timeout: reload FF at /2 overflows 512 cycles on
    cpu.op(0, '{8'hFF, 1'b0});
    n = 0;
    while (wrst !== 1'b1 && n < 600) begin
      tk(1);
      n++;
    end
    chk(16'(n), 16'(TMO_MIN_CYC));
    chk(rout_n, 1'b0);
    n = 0;
    while (wrst === 1'b1 && n < 600) begin
      tk(1);
      n++;
    end
    chk(16'(n), 16'h0200);
    tk(2);
    chk(run, 1'b1);
    chk(rout_n, 1'b0);
    // bootstrap mode swallows the overflow
    boot = 1'b1;
    cpu.op(0, '{8'hFF, 1'b0});
    tk(600);
    chk(wrst, 1'b0);
    give_verdict();
  end
endmodule
